/* File: hdl/fwp_pkg.sv */
// shared constants, types and protection decode for both link ends
package fwp_pkg;

	// ****************************************************************
	// command opcodes
	// ****************************************************************
	localparam logic [7:0] CMD_WRITE_ENABLE = 8'h06;
	localparam logic [7:0] CMD_WRITE_DISABLE = 8'h04;
	localparam logic [7:0] CMD_RESET_ENABLE = 8'h66;
	localparam logic [7:0] CMD_RESET_DEVICE = 8'h99;

	// ****************************************************************
	// timing
	// ****************************************************************
	localparam int CLOCK_KHZ = 40000;
	localparam int RESET_RECOVER_NS = 30000;
	// least time, so round up to whole cycles
	localparam int RESET_RECOVER_CYCLES =
		(RESET_RECOVER_NS * CLOCK_KHZ + 999999) / 1000000;
	localparam int SCK_HALF_CYCLES = 2;
	localparam int CS_GAP_CYCLES = 4;

	// ****************************************************************
	// array and protection field layout
	// ****************************************************************
	localparam int ADDR_W = 22;
	localparam int PROT_W = 6;
	localparam int PROT_CMP_BIT = 5;
	localparam int PROT_BOTTOM_BIT = 3;
	localparam int PROT_FINE_BIT = 4;
	localparam logic [PROT_W-1:0] PROT_RESET = 6'h00;
	localparam logic [4:0] SECTOR_SHIFT = 5'h0c;
	localparam logic [4:0] BLOCK_SHIFT = 5'h10;
	localparam logic [22:0] ARRAY_SIZE = 23'h40_0000;

	// ****************************************************************
	// host register map
	// ****************************************************************
	localparam logic [7:0] REG_CMD = 8'h00;
	localparam logic [7:0] REG_DATA = 8'h04;
	localparam logic [7:0] REG_STATUS = 8'h08;
	localparam int CMD_BITS_LSB = 8;
	localparam int STATUS_BUSY_BIT = 0;
	localparam int STATUS_RECOVER_BIT = 1;

	// kinds of write operation offered to the device's datapath side
	typedef enum logic [2:0] {
		OP_PROGRAM,
		OP_ERASE,
		OP_SEC_PROGRAM,
		OP_SEC_ERASE,
		OP_STATUS_WRITE
	} fwp_op_e;

	// true when addr lies in the region that prot selects
	function automatic logic fwp_is_protected(
		input logic [ADDR_W-1:0] addr,
		input logic [PROT_W-1:0] prot
	);
		logic [2:0] lvl;
		logic [4:0] sh;
		logic [22:0] size;
		logic hit;
		lvl = prot[2:0];
		// fine steps stop growing at 32 KB
		if (prot[PROT_FINE_BIT]) begin
			sh = SECTOR_SHIFT + ((lvl >= 3'h4) ? 5'h03 : {2'h0, lvl} - 5'h01);
		end else begin
			sh = BLOCK_SHIFT + {2'h0, lvl} - 5'h01;
		end
		size = 23'h00_0001 << sh;
		if (lvl == 3'h0) begin
			hit = 1'b0;
		end else if (lvl == 3'h7) begin
			hit = 1'b1;
		end else if (prot[PROT_BOTTOM_BIT]) begin
			hit = {1'b0, addr} < size;
		end else begin
			hit = {1'b0, addr} >= (ARRAY_SIZE - size);
		end
		return hit ^ prot[PROT_CMP_BIT];
	endfunction

endpackage

/* File: hdl/fwp_link_if.sv */
// serial link between host controller and flash protection end
interface fwp_link_if;
	logic csN;
	logic sck;
	logic mosi;
	modport host (output csN, output sck, output mosi);
	modport dev (input csN, input sck, input mosi);
endinterface

/* File: hdl/fwp_device.sv */
// device end: write-enable latch, block protection and soft reset
//
// Chosen here: register access over AHB-Lite and the register offsets.
module fwp_device #(
	parameter int RECOVER_CYCLES = fwp_pkg::RESET_RECOVER_CYCLES,
	parameter logic [fwp_pkg::PROT_W-1:0] PROT_INIT = fwp_pkg::PROT_RESET
) (
	input wire logic clock,
	input wire logic rstn,
	fwp_link_if.dev link,
	input wire logic writeProtectN,
	input wire logic opRequest,
	input wire fwp_pkg::fwp_op_e opKind,
	input wire logic [fwp_pkg::ADDR_W-1:0] opAddr,
	input wire logic [fwp_pkg::PROT_W-1:0] opStatusValue,
	input wire logic opDone,
	output logic opGrant,
	output logic opRefused,
	output logic writeEnableLatch,
	output logic [fwp_pkg::PROT_W-1:0] protectBits,
	output logic resetPulse,
	output logic recovering
);

	localparam int RECOVER_W = $clog2(RECOVER_CYCLES + 1);
	localparam logic [RECOVER_W-1:0] RECOVER_LOAD =
		RECOVER_W'(RECOVER_CYCLES);

	// ****************************************************************
	// state
	// ****************************************************************
	typedef struct packed {
		logic [1:0] csSync;
		logic [1:0] sckSync;
		logic [1:0] mosiSync;
		logic [1:0] wpSync;
		logic sckPrev;
		logic inFrame;
		logic gotOpcode;
		logic [2:0] bitPhase;
		logic [7:0] shift;
		logic [7:0] opcode;
		logic write_enable_latch;
		logic resetArmed;
		logic [fwp_pkg::PROT_W-1:0] prot;
		logic [RECOVER_W-1:0] recover;
		logic resetPulse;
		logic grant;
		logic refused;
	} fwp_dev_state_s;

	fwp_dev_state_s s_reg;
	fwp_dev_state_s s_next;
	logic csLevel;
	logic sckLevel;
	logic mosiLevel;
	logic wpLevel;
	logic sckRise;
	logic busyRecover;
	logic aligned;
	logic doReset;
	logic [7:0] shiftNew;

	// ****************************************************************
	// next-state logic
	// ****************************************************************
	always_comb begin
		s_next = s_reg;
		shiftNew = {s_reg.shift[6:0], s_reg.mosiSync[1]};
		aligned = 1'b0;
		doReset = 1'b0;
		s_next.resetPulse = 1'b0;
		s_next.grant = 1'b0;
		s_next.refused = 1'b0;

		// pins cross in through two flops; only stage two is read
		s_next.csSync = {s_reg.csSync[0], link.csN};
		s_next.sckSync = {s_reg.sckSync[0], link.sck};
		s_next.mosiSync = {s_reg.mosiSync[0], link.mosi};
		s_next.wpSync = {s_reg.wpSync[0], writeProtectN};
		csLevel = s_reg.csSync[1];
		sckLevel = s_reg.sckSync[1];
		mosiLevel = s_reg.mosiSync[1];
		wpLevel = s_reg.wpSync[1];
		s_next.sckPrev = sckLevel;
		sckRise = sckLevel && !s_reg.sckPrev;
		busyRecover = s_reg.recover != '0;

		// recovery window after an accepted reset
		if (busyRecover) begin
			s_next.recover = s_reg.recover - 1'b1;
		end

		// write operations from the datapath side; latch sampled as it
		// stood when the request arrived
		if (opRequest) begin
			if (busyRecover || !s_reg.write_enable_latch) begin
				s_next.refused = 1'b1;
			end else if (opKind == fwp_pkg::OP_STATUS_WRITE) begin
				// pin locks the bits only; latch stays for a retry
				if (!wpLevel) begin
					s_next.refused = 1'b1;
				end else begin
					s_next.prot = opStatusValue;
					s_next.write_enable_latch = 1'b0;
					s_next.grant = 1'b1;
				end
			end else if ((opKind == fwp_pkg::OP_PROGRAM ||
				opKind == fwp_pkg::OP_ERASE) &&
				fwp_pkg::fwp_is_protected(opAddr, s_reg.prot)) begin
				s_next.refused = 1'b1;
				s_next.write_enable_latch = 1'b0;
			end else begin
				// the protect pin plays no part here
				s_next.grant = 1'b1;
			end
		end

		// end of a self-timed cycle drops the latch
		if (opDone) begin
			s_next.write_enable_latch = 1'b0;
		end

		// serial frame: mode 0, bits taken on sck rising
		if (!csLevel) begin
			if (!s_reg.inFrame) begin
				s_next.inFrame = 1'b1;
				s_next.gotOpcode = 1'b0;
				s_next.bitPhase = 3'h0;
			end else if (sckRise) begin
				s_next.shift = shiftNew;
				s_next.bitPhase = s_reg.bitPhase + 3'h1;
				// later bytes only move the phase, never the opcode
				if (s_reg.bitPhase == 3'h7 && !s_reg.gotOpcode) begin
					s_next.opcode = shiftNew;
					s_next.gotOpcode = 1'b1;
				end
			end
		end else if (s_reg.inFrame) begin
			// frame ends on release of chip select
			s_next.inFrame = 1'b0;
			aligned = s_reg.gotOpcode && s_reg.bitPhase == 3'h0;
			if (!busyRecover && s_reg.gotOpcode) begin
				// any complete command other than reset enable disarms
				s_next.resetArmed = 1'b0;
				if (aligned) begin
					case (s_reg.opcode)
						fwp_pkg::CMD_WRITE_ENABLE: begin
							s_next.write_enable_latch = 1'b1;
						end
						fwp_pkg::CMD_WRITE_DISABLE: begin
							s_next.write_enable_latch = 1'b0;
						end
						fwp_pkg::CMD_RESET_ENABLE: begin
							s_next.resetArmed = 1'b1;
						end
						fwp_pkg::CMD_RESET_DEVICE: begin
							doReset = s_reg.resetArmed;
						end
						default: begin
							doReset = 1'b0;
						end
					endcase
				end
			end
		end

		// accepted reset: volatile state back to power-on values,
		// protection bits are non-volatile and survive
		if (doReset) begin
			s_next.write_enable_latch = 1'b0;
			s_next.resetArmed = 1'b0;
			s_next.resetPulse = 1'b1;
			s_next.recover = RECOVER_LOAD;
		end
	end

	// ****************************************************************
	// state register
	// ****************************************************************
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			s_reg <= '0;
			s_reg.csSync <= 2'h3;
			s_reg.wpSync <= 2'h3;
			s_reg.prot <= PROT_INIT;
		end else begin
			s_reg <= s_next;
		end
	end

	// outputs straight from the state flops; recovering is a compare on the recover counter
	assign opGrant = s_reg.grant;
	assign opRefused = s_reg.refused;
	assign writeEnableLatch = s_reg.write_enable_latch;
	assign protectBits = s_reg.prot;
	assign resetPulse = s_reg.resetPulse;
	assign recovering = s_reg.recover != '0;

endmodule

/* File: hdl/fwp_host.sv */
// host end: AHB-Lite command registers driving the serial link
module fwp_host #(
	parameter int SCK_HALF = fwp_pkg::SCK_HALF_CYCLES,
	parameter int GAP = fwp_pkg::CS_GAP_CYCLES,
	parameter int RECOVER_CYCLES = fwp_pkg::RESET_RECOVER_CYCLES
) (
	input wire logic clock,
	input wire logic rstn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic [31:0] hrdata,
	output logic hresp,
	fwp_link_if.host link
);

	localparam int DIV_W = $clog2(SCK_HALF + 1);
	localparam int GAP_W = $clog2(GAP + 1);
	localparam int REC_W = $clog2(RECOVER_CYCLES + 1);

	typedef enum logic [2:0] {
		H_IDLE, H_SHIFT, H_TAIL, H_GAP, H_RECOVER
	} fwp_host_state_e;

	// ****************************************************************
	// state
	// ****************************************************************
	typedef struct packed {
		fwp_host_state_e state;
		logic [7:0] cmdOp;
		logic [5:0] cmdBits;
		logic [23:0] dataReg;
		logic [31:0] shift;
		logic [5:0] bitsLeft;
		logic [DIV_W-1:0] div;
		logic [GAP_W-1:0] gap;
		logic [REC_W-1:0] recover;
		logic sck;
		logic csN;
		logic mosi;
		logic armed;
		logic sendReset;
		logic dAct;
		logic dWrite;
		logic [7:0] dAddr;
		logic [31:0] rdata;
	} fwp_host_state_s;

	fwp_host_state_s s_reg;
	fwp_host_state_s s_next;
	logic addrTaken;
	logic [5:0] newBits;
	logic newAligned;

	// ****************************************************************
	// next-state logic
	// ****************************************************************
	always_comb begin
		s_next = s_reg;
		addrTaken = hsel && hready && htrans[1];
		newBits = hwdata[fwp_pkg::CMD_BITS_LSB +: 6];
		newAligned = newBits[2:0] == 3'h0 && newBits != 6'h00;

		// address phase: read data is fetched here, zero wait states
		s_next.dAct = addrTaken;
		if (addrTaken) begin
			s_next.dWrite = hwrite;
			s_next.dAddr = haddr[7:0];
			case (haddr[7:0])
				fwp_pkg::REG_CMD: s_next.rdata = {18'h0_0000,
					s_reg.cmdBits, s_reg.cmdOp};
				fwp_pkg::REG_DATA: s_next.rdata = {8'h00, s_reg.dataReg};
				fwp_pkg::REG_STATUS: begin
					s_next.rdata = 32'h0000_0000;
					s_next.rdata[fwp_pkg::STATUS_BUSY_BIT] =
						s_reg.state != H_IDLE;
					s_next.rdata[fwp_pkg::STATUS_RECOVER_BIT] =
						s_reg.state == H_RECOVER;
				end
				default: s_next.rdata = 32'h0000_0000;
			endcase
		end

		// data phase writes; a command while busy is dropped
		if (s_reg.dAct && s_reg.dWrite) begin
			if (s_reg.dAddr == fwp_pkg::REG_DATA) begin
				s_next.dataReg = hwdata[23:0];
			end else if (s_reg.dAddr == fwp_pkg::REG_CMD &&
				s_reg.state == H_IDLE && newBits != 6'h00) begin
				s_next.cmdOp = hwdata[7:0];
				s_next.cmdBits = newBits;
				s_next.shift = {hwdata[7:0], s_reg.dataReg};
				s_next.bitsLeft = newBits;
				s_next.mosi = hwdata[7];
				s_next.csN = 1'b0;
				s_next.sck = 1'b0;
				s_next.div = '0;
				s_next.state = H_SHIFT;
				s_next.sendReset = 1'b0;
				// track the reset pair as the device will see it
				if (newBits >= 6'h08) begin
					s_next.sendReset = s_reg.armed && newAligned &&
						hwdata[7:0] == fwp_pkg::CMD_RESET_DEVICE;
					s_next.armed = newAligned &&
						hwdata[7:0] == fwp_pkg::CMD_RESET_ENABLE;
				end
			end
		end

		// serial engine
		case (s_reg.state)
			H_SHIFT: begin
				s_next.div = s_reg.div + 1'b1;
				if (s_reg.div == DIV_W'(SCK_HALF - 1)) begin
					s_next.div = '0;
					s_next.sck = !s_reg.sck;
					// bit completes on the falling half
					if (s_reg.sck) begin
						s_next.shift = {s_reg.shift[30:0], 1'b0};
						s_next.mosi = s_reg.shift[30];
						s_next.bitsLeft = s_reg.bitsLeft - 6'h01;
						if (s_reg.bitsLeft == 6'h01) begin
							s_next.gap = '0;
							s_next.state = H_TAIL;
						end
					end
				end
			end
			H_TAIL: begin
				// hold select past the last edge so the far end sees it
				s_next.gap = s_reg.gap + 1'b1;
				if (s_reg.gap == GAP_W'(GAP - 1)) begin
					s_next.gap = '0;
					s_next.csN = 1'b1;
					s_next.state = H_GAP;
				end
			end
			H_GAP: begin
				s_next.gap = s_reg.gap + 1'b1;
				if (s_reg.gap == GAP_W'(GAP - 1)) begin
					s_next.recover = REC_W'(RECOVER_CYCLES);
					s_next.state = s_reg.sendReset ? H_RECOVER : H_IDLE;
					s_next.armed = s_reg.sendReset ? 1'b0 : s_reg.armed;
				end
			end
			H_RECOVER: begin
				// no new command until the device has recovered
				s_next.recover = s_reg.recover - 1'b1;
				if (s_reg.recover == REC_W'(1)) begin
					s_next.state = H_IDLE;
				end
			end
			default: begin
				s_next.sck = 1'b0;
			end
		endcase
	end

	// ****************************************************************
	// state register
	// ****************************************************************
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			s_reg <= '0;
			s_reg.state <= H_IDLE;
			s_reg.csN <= 1'b1;
		end else begin
			s_reg <= s_next;
		end
	end

	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = s_reg.rdata;
	assign link.csN = s_reg.csN;
	assign link.sck = s_reg.sck;
	assign link.mosi = s_reg.mosi;

endmodule

/* File: tb/fwp_sva.sv */
// serial link checker watching the wires between host and device ends
module fwp_sva #(
	parameter int RECOVER_CYCLES = fwp_pkg::RESET_RECOVER_CYCLES
) (
	input wire logic clock,
	input wire logic rstn,
	input wire logic csN,
	input wire logic sck,
	input wire logic mosi
);
	timeunit 1ns;
	timeprecision 1ps;
	// ****
	// frame decode helpers
	// ****
	logic [5:0] bitCnt_reg;
	logic [7:0] op_reg;
	logic armed_reg;
	logic csPrev_reg;
	logic sckPrev_reg;
	int quiet_reg;
	logic whole;
	assign whole = bitCnt_reg != 6'h00 && bitCnt_reg[2:0] == 3'h0;
	// short frames leave the arm state alone, misaligned ones disarm
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			bitCnt_reg <= 6'h00;
			op_reg <= 8'h00;
			armed_reg <= 1'b0;
			csPrev_reg <= 1'b1;
			sckPrev_reg <= 1'b0;
			quiet_reg <= 0;
		end else begin
			csPrev_reg <= csN;
			sckPrev_reg <= sck;
			if (quiet_reg != 0) begin
				quiet_reg <= quiet_reg - 1;
			end
			if (!csN && sck && !sckPrev_reg) begin
				bitCnt_reg <= bitCnt_reg + 6'h01;
				if (bitCnt_reg < 6'h08) begin
					op_reg <= {op_reg[6:0], mosi}; // opcode msb first
				end
			end
			if (csN && !csPrev_reg) begin
				bitCnt_reg <= 6'h00;
				if (bitCnt_reg >= 6'h08) begin
					armed_reg <= whole && op_reg == fwp_pkg::CMD_RESET_ENABLE;
				end
				if (armed_reg && whole && op_reg == fwp_pkg::CMD_RESET_DEVICE) begin
					quiet_reg <= RECOVER_CYCLES - 1;
				end
			end
		end
	end

	// ****
	// wire rules
	// ****
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!rstn);

	chk_idle_sck: assert property (csN |-> !sck)
		else $error("serial clock moved while deselected");
	chk_select_lead: assert property ($fell(csN) |=> !sck)
		else $error("serial clock rose too soon after select");
	chk_mosi_hold: assert property ($rose(sck) |=> $stable(mosi))
		else $error("data changed while serial clock high");
	chk_high_len: assert property ($rose(sck) |=> sck)
		else $error("serial clock high phase too short");
	chk_low_len: assert property ($fell(sck) |=> !sck)
		else $error("serial clock low phase too short");
	chk_deselect_len: assert property ($rose(csN) |=> csN [*3])
		else $error("deselect time too short");
	chk_tail_len: assert property ($rose(csN) |->
		!$past(sck, 4) && !$past(sck))
		else $error("select released too soon after last bit");
	chk_recover_quiet: assert property (quiet_reg != 0 |-> csN)
		else $error("frame started during reset recovery");

	cov_whole: cover property ($rose(csN) && bitCnt_reg == 6'h08);
	cov_partial: cover property ($rose(csN) && !whole);
	cov_reset: cover property (quiet_reg == RECOVER_CYCLES - 1);
endmodule

/* File: tb/tb_top.sv */
// self-checking bench joining the host and device ends across the link
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int REC = 20;
	localparam logic [5:0] PROTS [12] = '{6'h01, 6'h01, 6'h09, 6'h09,
		6'h11, 6'h11, 6'h1d, 6'h16, 6'h21, 6'h21, 6'h20, 6'h3a};
	localparam logic [21:0] ADDRS [12] = '{22'h3f_0000, 22'h3e_ffff,
		22'h00_ffff, 22'h01_0000, 22'h3f_f000, 22'h3f_efff, 22'h00_8000,
		22'h3f_7fff, 22'h3e_ffff, 22'h3f_0000, 22'h3f_ffff, 22'h00_1fff};
	localparam logic [11:0] HITS = 12'h515;
	logic clock, rstn, hsel, hwrite, hready, hresp;
	logic [31:0] haddr, hwdata, hrdata;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic writeProtectN, opRequest, opDone, opGrant, opRefused, write_enable_latch;
	logic resetPulse, recovering;
	fwp_pkg::fwp_op_e opKind;
	logic [21:0] opAddr;
	logic [5:0] opStatusValue, protectBits;
	int miscompares, checks_done, resets, recCycles;
	fwp_link_if link();

	fwp_host #(.RECOVER_CYCLES(REC)) i_fwp_host (.clock(clock), .rstn(rstn),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(hsize), .hwdata(hwdata), .hready(hready),
		.hreadyout(hready), .hrdata(hrdata), .hresp(hresp), .link(link));
	fwp_device #(.RECOVER_CYCLES(REC)) i_fwp_device (.clock(clock),
		.rstn(rstn), .link(link), .writeProtectN(writeProtectN),
		.opRequest(opRequest), .opKind(opKind), .opAddr(opAddr),
		.opStatusValue(opStatusValue), .opDone(opDone), .opGrant(opGrant),
		.opRefused(opRefused), .writeEnableLatch(write_enable_latch),
		.protectBits(protectBits), .resetPulse(resetPulse),
		.recovering(recovering));
	fwp_sva #(.RECOVER_CYCLES(REC)) i_fwp_sva (.clock(clock), .rstn(rstn),
		.csN(link.csN), .sck(link.sck), .mosi(link.mosi));

	// ****
	// clock, monitors and compares
	// ****
	initial begin
		clock = 1'b0;
		forever #12.5 clock = ~clock;
	end
	// pulses are counted as they pass, recovery length too
	always @(posedge clock) begin
		if (resetPulse === 1'b1) resets++;
		if (recovering === 1'b1) recCycles++;
	end
	task automatic check_bit(input logic got, input logic exp);
		checks_done++;
		if (got !== exp) begin
			miscompares++;
			$display("mismatch at %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			miscompares++;
			$display("mismatch at %0t got %h exp %h", $time, got, exp);
		end
	endtask

	// ****
	// bus and port drivers
	// ****
	// address phase held until hready, then data phase until hready
	task automatic ahb(input logic wr, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] rd);
		@(posedge clock);
		hsel <= 1'b1;
		htrans <= 2'b10;
		hwrite <= wr;
		haddr <= {24'h00_0000, a};
		@(posedge clock);
		while (hready !== 1'b1) @(posedge clock);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= d;
		@(posedge clock);
		while (hready !== 1'b1) @(posedge clock);
		rd = hrdata;
	endtask
	// trailing bits carry a pattern the device must ignore
	task automatic frame(input logic [7:0] opc, input logic [5:0] n);
		logic [31:0] rd;
		ahb(1'b1, fwp_pkg::REG_DATA, 32'h00a5_5a5a, rd);
		ahb(1'b1, fwp_pkg::REG_CMD, {18'h0_0000, n, opc}, rd);
		rd = 32'h0000_0001;
		while (rd[1:0] !== 2'b00) begin
			ahb(1'b0, fwp_pkg::REG_STATUS, 32'h0000_0000, rd);
		end
		repeat (8) @(posedge clock); // sync delay of the device
	endtask
	task automatic do_op(input fwp_pkg::fwp_op_e k, input logic [21:0] a,
		input logic [5:0] v, input logic g);
		@(posedge clock);
		opRequest <= 1'b1;
		opKind <= k;
		opAddr <= a;
		opStatusValue <= v;
		@(posedge clock);
		opRequest <= 1'b0;
		#1;
		check_bit(opGrant, g);
		check_bit(opRefused, !g);
	endtask

	// ****
	// scenarios
	// ****
	task automatic t_latch();
		logic [31:0] rd;
		frame(fwp_pkg::CMD_WRITE_ENABLE, 6'h08);
		check_bit(write_enable_latch, 1'b1);
		frame(fwp_pkg::CMD_WRITE_DISABLE, 6'h18);
		check_bit(write_enable_latch, 1'b0);
		frame(fwp_pkg::CMD_WRITE_ENABLE, 6'h05);
		check_bit(write_enable_latch, 1'b0);
		frame(fwp_pkg::CMD_WRITE_ENABLE, 6'h10);
		check_bit(write_enable_latch, 1'b1);
		frame(fwp_pkg::CMD_WRITE_DISABLE, 6'h0c);
		check_bit(write_enable_latch, 1'b1);
		// command and data words read back as last written
		ahb(1'b0, fwp_pkg::REG_CMD, 32'h0000_0000, rd);
		check_word(rd, 32'h0000_0c04);
		ahb(1'b0, fwp_pkg::REG_DATA, 32'h0000_0000, rd);
		check_word(rd, 32'h00a5_5a5a);
		ahb(1'b0, 8'h10, 32'h0000_0000, rd);
		check_word(rd, 32'h0000_0000);
		check_bit(hresp, 1'b0);
		$display("test latch done");
	endtask
	task automatic t_gate();
		frame(fwp_pkg::CMD_WRITE_DISABLE, 6'h08);
		for (int k = 0; k < 5; k++) begin
			do_op(fwp_pkg::fwp_op_e'(k), 22'h00_0000, 6'h00, 1'b0);
		end
		frame(fwp_pkg::CMD_WRITE_ENABLE, 6'h08);
		writeProtectN <= 1'b0;
		repeat (4) @(posedge clock);
		do_op(fwp_pkg::OP_STATUS_WRITE, 22'h00_0000, 6'h01, 1'b0);
		check_bit(write_enable_latch, 1'b1);
		do_op(fwp_pkg::OP_ERASE, 22'h00_0100, 6'h00, 1'b1);
		@(posedge clock);
		opDone <= 1'b1;
		@(posedge clock);
		opDone <= 1'b0;
		writeProtectN <= 1'b1;
		#1;
		check_bit(write_enable_latch, 1'b0);
		repeat (4) @(posedge clock);
		$display("test gate done");
	endtask
	task automatic t_decode();
		for (int i = 0; i < 12; i++) begin
			frame(fwp_pkg::CMD_WRITE_ENABLE, 6'h08);
			do_op(fwp_pkg::OP_STATUS_WRITE, 22'h00_0000, PROTS[i], 1'b1);
			check_word({26'h000_0000, protectBits}, {26'h000_0000, PROTS[i]});
			frame(fwp_pkg::CMD_WRITE_ENABLE, 6'h08);
			do_op(i[0] ? fwp_pkg::OP_ERASE : fwp_pkg::OP_PROGRAM, ADDRS[i],
				6'h00, !HITS[i]);
			check_bit(write_enable_latch, !HITS[i]);
		end
		$display("test decode done");
	endtask
	task automatic t_reset();
		logic [31:0] rd;
		logic seen;
		frame(fwp_pkg::CMD_RESET_ENABLE, 6'h08);
		frame(fwp_pkg::CMD_WRITE_ENABLE, 6'h08);
		frame(fwp_pkg::CMD_RESET_DEVICE, 6'h08);
		check_word(resets, 32'h0000_0000);
		check_bit(write_enable_latch, 1'b1);
		// host side idle before the reset pair goes out
		ahb(1'b0, fwp_pkg::REG_STATUS, 32'h0000_0000, rd);
		check_word(rd, 32'h0000_0000);
		frame(fwp_pkg::CMD_RESET_ENABLE, 6'h08);
		// a write enable queued behind the reset must be dropped
		ahb(1'b1, fwp_pkg::REG_CMD, {18'h0_0000, 6'h08,
			fwp_pkg::CMD_RESET_DEVICE}, rd);
		ahb(1'b1, fwp_pkg::REG_CMD, {18'h0_0000, 6'h08,
			fwp_pkg::CMD_WRITE_ENABLE}, rd);
		seen = 1'b0;
		rd = 32'h0000_0001;
		while (rd[1:0] !== 2'b00) begin
			ahb(1'b0, fwp_pkg::REG_STATUS, 32'h0000_0000, rd);
			seen = seen | rd[1];
		end
		repeat (8) @(posedge clock);
		check_bit(seen, 1'b1);
		check_word(resets, 32'h0000_0001);
		check_bit(write_enable_latch, 1'b0);
		check_word({26'h000_0000, protectBits}, 32'h0000_003a);
		check_word(recCycles, REC);
		frame(fwp_pkg::CMD_WRITE_ENABLE, 6'h08);
		check_bit(write_enable_latch, 1'b1);
		$display("test reset done");
	endtask

	task automatic finish_test();
		$display("checks %0d mismatches %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	// main sequence
	initial begin
		rstn = 1'b0;
		hsel = 1'b0;
		haddr = 32'h0000_0000;
		htrans = 2'b00;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0000_0000;
		writeProtectN = 1'b1;
		opRequest = 1'b0;
		opKind = fwp_pkg::OP_PROGRAM;
		opAddr = 22'h00_0000;
		opStatusValue = 6'h00;
		opDone = 1'b0;
		repeat (20) @(posedge clock);
		rstn <= 1'b1;
		t_latch();
		t_gate();
		t_decode();
		t_reset();
		finish_test();
	end
	// a hang counts as a mismatch
	initial begin
		repeat (60000) @(posedge clock);
		miscompares++;
		finish_test();
	end
endmodule
